//--- design/emi_cfg.svh
// Offsets, field positions, reset values and timing counts of the interface
`ifndef EMI_CFG_SVH
`define EMI_CFG_SVH
`define EMI_OFS_CONFIG 8'h00
`define EMI_OFS_PAGE 8'h01
`define EMI_OFS_TIMING 8'h02
`define EMI_OFS_STATUS 8'h03
`define EMI_RST_CONFIG 8'h03
`define EMI_RST_PAGE 8'h00
`define EMI_RST_TIMING 8'hff
`define EMI_CONFIG_MASK 8'h1f
`define EMI_BIT_FORM 4
`define EMI_MODE_HI 3
`define EMI_MODE_LO 2
`define EMI_ALE_HI 1
`define EMI_ALE_LO 0
`define EMI_SETUP_HI 7
`define EMI_SETUP_LO 6
`define EMI_WIDTH_HI 5
`define EMI_WIDTH_LO 2
`define EMI_HOLD_HI 1
`define EMI_HOLD_LO 0
`define EMI_ONCHIP_TOP 16'h2000
`define EMI_XRAM_AW 13
`define EMI_FIXED_OVH 4
`define EMI_TAIL_CYC (`EMI_FIXED_OVH - 1)
`define EMI_RD_DELAY 3
`endif

//--- design/emi_pkg.sv
// Types shared by the external data memory interface files
package emi_pkg;
   typedef enum logic [1:0] {
      EMI_INT_ONLY,
      EMI_SPLIT_NOBANK,
      EMI_SPLIT_BANK,
      EMI_EXT_ONLY
   } emi_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ONCHIP,
      ST_LAUNCH,
      ST_ALEH,
      ST_ALEL,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_TAIL
   } emi_state_t;

   // One move from the core
   typedef struct packed {
      logic wr;
      logic wide;
      logic [15:0] dptr;
      logic [7:0] ri;
      logic [7:0] wdata;
   } emi_move_t;

   // Pin outputs; every output enable is active low, ALE is active high
   typedef struct packed {
      logic ale;
      logic rd_n;
      logic wr_n;
      logic [7:0] ad_o;
      logic ad_oe_n;
      logic [7:0] lo_o;
      logic lo_oe_n;
      logic [7:0] hi_o;
      logic hi_oe_n;
   } emi_pins_t;
endpackage

//--- design/emi_sync.sv
// Two-stage synchroniser for the shared data pins
`timescale 1ns/1ps
module emi_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   logic [7:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r <= 8'h00;
         dout <= 8'h00;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule

//--- design/emi_xram.sv
// On-chip XRAM, 8 k bytes, registered read
`timescale 1ns/1ps
`include "emi_cfg.svh"
module emi_xram (
   input wire logic core_clk,
   input wire logic en,
   input wire logic we,
   input wire logic [`EMI_XRAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:(1<<`EMI_XRAM_AW)-1];

   // Write stores, read returns in the next cycle
   always_ff @(posedge core_clk) begin
      if (en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end
endmodule

//--- design/emi_top.sv
// External data memory interface: mode steering, XRAM and bus timing
// What this block does
// RULE1 - Config bit 4 clear gives multiplexed bus, set gives separate pins.
// RULE2 - Multiplexed: low address byte and data share the same eight pins.
// RULE3 - ALE high while low address is on shared pins; latch holds from fall.
// RULE4 - After ALE, shared pins hold data in strobe: driven or sampled.
// RULE5 - Non-multiplexed: address and data on separate pins, no latch phase.
// RULE6 - Mode 00: every move goes on-chip, address wraps modulo 8 k.
// RULE7 - 8-bit move address is page register high byte, R0/R1 low byte.
// RULE8 - 16-bit move takes its full address from the data pointer.
// RULE9 - Mode 01: below 8 k on-chip, above goes off-chip.
// RULE10 - Mode 01 off-chip 8-bit move drives low byte only, not upper.
// RULE11 - Off-chip 16-bit move drives all sixteen address lines.
// RULE12 - Mode 10 off-chip 8-bit move drives page byte high, R0/R1 low.
// RULE13 - Mode 11: all moves off-chip, 8-bit ignores page, upper undriven.
// RULE14 - Setup, hold, strobe width and ALE width programmable in clocks.
// RULE15 - Off-chip move lasts programmed times plus four fixed clocks.
// RULE16 - Multiplexed form adds at least two clocks for the ALE phase.
// RULE17 - Timing register resets to all ones, maximum delays.
// RULE18 - Strobe width field bits 5..2 gives code plus one clocks.
// RULE19 - Setup bits 7..6 and hold bits 1..0 give code clocks.
// RULE20 - Address setup adjustable from zero to three clocks.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "emi_cfg.svh"
module emi_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic mv_req,
   input wire emi_pkg::emi_move_t mv,
   output logic mv_busy,
   output logic mv_done,
   output logic [7:0] mv_rdata,
   input wire logic [7:0] data_i,
   output emi_pkg::emi_pins_t pins
);
   // ***************************************************************
   // Functions
   // ***************************************************************

   // Whether an effective address leaves the chip in a given mode
   function automatic logic is_offchip(emi_pkg::emi_mode_t m,
                                       logic [15:0] a);
      logic r;
      case (m)
         emi_pkg::EMI_INT_ONLY: r = 1'b0; // RULE6
         emi_pkg::EMI_EXT_ONLY: r = 1'b1; // RULE13
         default: r = (a >= `EMI_ONCHIP_TOP); // RULE9
      endcase
      return r;
   endfunction

   // First state after the address phase: setup or straight to strobe
   function automatic emi_pkg::emi_state_t after_addr(logic [1:0] s);
      return (s != 2'b00) ? emi_pkg::ST_SETUP : emi_pkg::ST_STROBE;
   endfunction

   // Count loaded on entry to the state chosen by after_addr
   function automatic logic [3:0] after_cnt(logic [1:0] s,
                                            logic [3:0] w);
      return (s != 2'b00) ? {2'b00, s} - 4'h1 : w;
   endfunction

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [7:0] config_r;
   logic [7:0] page_r;
   logic [7:0] timing_r;
   logic offchip_last_r;

   // Software writes to the control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         config_r <= `EMI_RST_CONFIG;
         page_r <= `EMI_RST_PAGE;
         timing_r <= `EMI_RST_TIMING; // RULE17
      end else if (reg_wr) begin
         case (reg_addr)
            `EMI_OFS_CONFIG: config_r <= reg_wdata & `EMI_CONFIG_MASK;
            `EMI_OFS_PAGE: page_r <= reg_wdata;
            `EMI_OFS_TIMING: timing_r <= reg_wdata; // RULE14
            default: ;
         endcase
      end
   end

   // Read data stands in the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `EMI_OFS_CONFIG: reg_rdata <= config_r;
            `EMI_OFS_PAGE: reg_rdata <= page_r;
            `EMI_OFS_TIMING: reg_rdata <= timing_r;
            `EMI_OFS_STATUS: reg_rdata <= {6'h00, offchip_last_r,
                                           mv_busy};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ***************************************************************
   // Request decode
   // ***************************************************************
   emi_pkg::emi_mode_t mode;
   logic [15:0] eff;
   logic off_now;
   logic hi_drv_now;

   // Effective address and target of the incoming move
   always_comb begin
      mode = emi_pkg::emi_mode_t'(config_r[`EMI_MODE_HI:`EMI_MODE_LO]);
      if (mv.wide) begin
         eff = mv.dptr; // RULE8
      end else begin
         eff = {page_r, mv.ri}; // RULE7
      end
      off_now = is_offchip(mode, eff);
      hi_drv_now = mv.wide || mode == emi_pkg::EMI_SPLIT_BANK; // RULE11 RULE12
   end

   // ***************************************************************
   // Move context, latched when a move is taken
   // ***************************************************************
   logic [15:0] eff_r;
   logic wr_r;
   logic [7:0] wdata_r;
   logic hi_drv_r;
   logic mux_r;
   logic [7:0] tim_r;
   logic [1:0] ale_r;
   emi_pkg::emi_state_t state_r;
   emi_pkg::emi_state_t state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic take;

   assign take = mv_req && (state_r == emi_pkg::ST_IDLE);

   // Snapshot so a register rewrite cannot bend a running move
   always_ff @(posedge core_clk) begin
      if (rst) begin
         eff_r <= 16'h0000;
         wr_r <= 1'b0;
         wdata_r <= 8'h00;
         hi_drv_r <= 1'b0;
         mux_r <= 1'b0;
         tim_r <= `EMI_RST_TIMING;
         ale_r <= 2'b00;
         offchip_last_r <= 1'b0;
      end else if (take) begin
         eff_r <= eff;
         wr_r <= mv.wr;
         wdata_r <= mv.wdata;
         hi_drv_r <= hi_drv_now;
         mux_r <= ~config_r[`EMI_BIT_FORM]; // RULE1
         tim_r <= timing_r;
         ale_r <= config_r[`EMI_ALE_HI:`EMI_ALE_LO];
         offchip_last_r <= off_now;
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   logic [1:0] setup_c;
   logic [3:0] width_c;
   logic [1:0] hold_c;

   assign setup_c = tim_r[`EMI_SETUP_HI:`EMI_SETUP_LO]; // RULE19 RULE20
   assign width_c = tim_r[`EMI_WIDTH_HI:`EMI_WIDTH_LO]; // RULE18
   assign hold_c = tim_r[`EMI_HOLD_HI:`EMI_HOLD_LO]; // RULE19

   // Phase order: launch, ALE high/low, setup, strobe, hold, tail
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
      case (state_r)
         emi_pkg::ST_IDLE: begin
            if (take) begin
               state_nxt = off_now ? emi_pkg::ST_LAUNCH
                                   : emi_pkg::ST_ONCHIP;
            end
         end
         emi_pkg::ST_ONCHIP: state_nxt = emi_pkg::ST_IDLE;
         emi_pkg::ST_LAUNCH: begin
            if (mux_r) begin
               state_nxt = emi_pkg::ST_ALEH; // RULE16
               cnt_nxt = {2'b00, ale_r};
            end else begin
               state_nxt = after_addr(setup_c); // RULE5
               cnt_nxt = after_cnt(setup_c, width_c);
            end
         end
         emi_pkg::ST_ALEH: begin
            if (cnt_r == 4'h0) begin
               state_nxt = emi_pkg::ST_ALEL;
               cnt_nxt = {2'b00, ale_r};
            end
         end
         emi_pkg::ST_ALEL: begin
            if (cnt_r == 4'h0) begin
               state_nxt = after_addr(setup_c);
               cnt_nxt = after_cnt(setup_c, width_c);
            end
         end
         emi_pkg::ST_SETUP: begin
            if (cnt_r == 4'h0) begin
               state_nxt = emi_pkg::ST_STROBE;
               cnt_nxt = width_c; // RULE18
            end
         end
         emi_pkg::ST_STROBE: begin
            if (cnt_r == 4'h0) begin
               if (hold_c != 2'b00) begin
                  state_nxt = emi_pkg::ST_HOLD;
                  cnt_nxt = {2'b00, hold_c} - 4'h1;
               end else begin
                  state_nxt = emi_pkg::ST_TAIL;
                  cnt_nxt = 4'(`EMI_TAIL_CYC - 1); // RULE15
               end
            end
         end
         emi_pkg::ST_HOLD: begin
            if (cnt_r == 4'h0) begin
               state_nxt = emi_pkg::ST_TAIL;
               cnt_nxt = 4'(`EMI_TAIL_CYC - 1); // RULE15
            end
         end
         emi_pkg::ST_TAIL: begin
            if (cnt_r == 4'h0) begin
               state_nxt = emi_pkg::ST_IDLE;
            end
         end
         default: state_nxt = emi_pkg::ST_IDLE;
      endcase
   end

   // State and phase counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= emi_pkg::ST_IDLE;
         cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ***************************************************************
   // On-chip XRAM
   // ***************************************************************
   logic [7:0] xram_rdata;

   emi_xram u_xram (
      .core_clk(core_clk),
      .en(take && !off_now),
      .we(mv.wr),
      .addr(eff[`EMI_XRAM_AW-1:0]), // RULE6
      .wdata(mv.wdata),
      .rdata(xram_rdata)
   );

   // ***************************************************************
   // Read data return
   // ***************************************************************
   logic [7:0] data_s;
   logic [`EMI_RD_DELAY-1:0] rd_pipe_r;

   emi_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din(data_i),
      .dout(data_s)
   );

   // Marks strobe end, aged by pin register and synchroniser delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_pipe_r <= '0;
      end else begin
         rd_pipe_r <= {rd_pipe_r[`EMI_RD_DELAY-2:0],
                       (state_r == emi_pkg::ST_STROBE) &&
                       (cnt_r == 4'h0) && !wr_r};
      end
   end

   // Read result and completion pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mv_rdata <= 8'h00;
         mv_done <= 1'b0;
         mv_busy <= 1'b0;
      end else begin
         if (state_r == emi_pkg::ST_ONCHIP && !wr_r) begin
            mv_rdata <= xram_rdata;
         end else if (rd_pipe_r[`EMI_RD_DELAY-1]) begin
            mv_rdata <= data_s; // RULE4
         end
         mv_done <= (state_r == emi_pkg::ST_ONCHIP) ||
                    ((state_r == emi_pkg::ST_TAIL) && (cnt_r == 4'h0));
         mv_busy <= (state_nxt != emi_pkg::ST_IDLE);
      end
   end

   // ***************************************************************
   // Pin drive
   // ***************************************************************
   emi_pkg::emi_pins_t pins_nxt;
   logic active;
   logic data_ph;

   // Pins follow the phase of the current state, one cycle later
   always_comb begin
      active = (state_r != emi_pkg::ST_IDLE) &&
               (state_r != emi_pkg::ST_ONCHIP);
      data_ph = (state_r == emi_pkg::ST_SETUP) ||
                (state_r == emi_pkg::ST_STROBE) ||
                (state_r == emi_pkg::ST_HOLD);
      pins_nxt = '0;
      pins_nxt.rd_n = 1'b1;
      pins_nxt.wr_n = 1'b1;
      pins_nxt.ad_oe_n = 1'b1;
      pins_nxt.lo_oe_n = 1'b1;
      pins_nxt.hi_oe_n = 1'b1;
      if (active) begin
         // Upper byte only for a 16-bit move, or an 8-bit move in mode 10
         if (hi_drv_r) begin // RULE10 RULE13
            pins_nxt.hi_o = eff_r[15:8]; // RULE11 RULE12
            pins_nxt.hi_oe_n = 1'b0;
         end
         if (!mux_r) begin
            pins_nxt.lo_o = eff_r[7:0]; // RULE5
            pins_nxt.lo_oe_n = 1'b0;
         end
         if (mux_r && (state_r == emi_pkg::ST_ALEH ||
                       state_r == emi_pkg::ST_ALEL)) begin
            pins_nxt.ad_o = eff_r[7:0]; // RULE2
            pins_nxt.ad_oe_n = 1'b0;
            pins_nxt.ale = (state_r == emi_pkg::ST_ALEH); // RULE3
         end
         if (data_ph && wr_r) begin
            pins_nxt.ad_o = wdata_r; // RULE4
            pins_nxt.ad_oe_n = 1'b0;
         end
         if (state_r == emi_pkg::ST_STROBE) begin
            pins_nxt.rd_n = wr_r;
            pins_nxt.wr_n = ~wr_r;
         end
      end
   end

   // Registered pin outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pins <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad_o: 8'h00,
                   ad_oe_n: 1'b1, lo_o: 8'h00, lo_oe_n: 1'b1,
                   hi_o: 8'h00, hi_oe_n: 1'b1};
      end else begin
         pins <= pins_nxt;
      end
   end
endmodule

//--- verif/emi_top_assertions.sv
// Concurrent checks on the ports of the memory interface
`timescale 1ns/1ps
module emi_top_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic mv_req,
   input wire emi_pkg::emi_move_t mv,
   input wire logic mv_busy,
   input wire logic mv_done,
   input wire emi_pkg::emi_pins_t pins
);
   // ********************************
   // Shadows, snapshot and counters
   // ********************************
   logic [7:0] cfg_r, pg_r, tc_r, cfg_s, tc_s, wd_s, len_r, cnt_r, exp_len;
   logic [7:0] mux_len;
   logic [15:0] ea, ea_s;
   logic take, wide_s, off_s, hi_on, strb;
   assign take = mv_req && !mv_busy;
   assign ea = mv.wide ? mv.dptr : {pg_r, mv.ri};
   assign strb = !pins.rd_n || !pins.wr_n;
   assign hi_on = wide_s || cfg_s[3:2] == 2'b10;
   assign mux_len = cfg_s[4] ? 8'd0 : {5'd0, cfg_s[1:0], 1'b0} + 8'd2;
   assign exp_len = !off_s ? 8'd2 : 8'd6 + {6'd0, tc_s[7:6]}
      + {4'd0, tc_s[5:2]} + {6'd0, tc_s[1:0]} + mux_len;
   // Register shadows follow software writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_r <= 8'h03;
         pg_r <= 8'h00;
         tc_r <= 8'hff;
      end else if (reg_wr) begin
         case (reg_addr)
            8'h00: cfg_r <= reg_wdata & 8'h1f;
            8'h01: pg_r <= reg_wdata;
            8'h02: tc_r <= reg_wdata;
            default: ;
         endcase
      end
   end
   // Move snapshot, move length and strobe length
   always_ff @(posedge core_clk) begin
      if (take) begin
         cfg_s <= cfg_r;
         tc_s <= tc_r;
         ea_s <= ea;
         wide_s <= mv.wide;
         wd_s <= mv.wdata;
         off_s <= cfg_r[3:2] == 2'b11 ||
            (cfg_r[3:2] != 2'b00 && ea[15:13] != 3'b000);
      end
      len_r <= take ? 8'd1 : len_r + 8'd1;
      cnt_r <= (rst || !strb) ? 8'd0 : cnt_r + 8'd1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   move_len_a: assert property (mv_done |-> len_r == exp_len)
      else $error("move length differs from timing setting");
   strobe_width_a: assert property (
      $fell(strb) |-> cnt_r == {4'd0, tc_s[5:2]} + 8'd1)
      else $error("strobe width differs from timing setting");
   ale_addr_a: assert property (
      pins.ale |-> !cfg_s[4] && !pins.ad_oe_n && pins.ad_o == ea_s[7:0])
      else $error("latch enable without low address");
   mux_lo_a: assert property (mv_busy && !cfg_s[4] |-> pins.lo_oe_n)
      else $error("separate low address driven in shared form");
   sep_lo_a: assert property (
      strb && cfg_s[4] |-> !pins.lo_oe_n && pins.lo_o == ea_s[7:0])
      else $error("separate low address missing");
   wr_data_a: assert property (
      !pins.wr_n |-> pins.rd_n && !pins.ad_oe_n && pins.ad_o == wd_s)
      else $error("write data not on data pins");
   rd_free_a: assert property (
      !pins.rd_n |-> pins.ad_oe_n && !pins.ale)
      else $error("data pins driven during read");
   hi_addr_a: assert property (
      strb |-> pins.hi_oe_n == !hi_on &&
         (pins.hi_oe_n || pins.hi_o == ea_s[15:8]))
      else $error("upper address drive wrong");
   chip_quiet_a: assert property (
      mv_busy && !off_s |-> pins.rd_n && pins.wr_n && !pins.ale)
      else $error("bus cycle on on-chip move");
   done_pulse_a: assert property (mv_done |-> !mv_busy ##1 !mv_done)
      else $error("done not a single pulse");
endmodule
bind emi_top emi_top_assertions i_emi_top_assertions (.core_clk(core_clk),
   .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .mv_req(mv_req), .mv(mv), .mv_busy(mv_busy), .mv_done(mv_done),
   .pins(pins));

//--- verif/emi_sram_model.sv
// Behavioural external SRAM with its address latch
`timescale 1ns/1ps
module emi_sram_model #(
   parameter logic [7:0] HI_PORT = 8'h00
) (
   input wire logic core_clk,
   input wire emi_pkg::emi_pins_t pins,
   output logic [7:0] data_i
);
   // ********************************
   // Latch, storage and data lines
   // ********************************
   logic [7:0] mem [0:65535];
   logic [7:0] latch_q;
   logic [7:0] junk_r = 8'h55;
   logic [15:0] addr;
   // Latch passes while enable is high, freezes when it falls
   always_latch begin
      if (pins.ale) begin
         latch_q <= pins.ad_o;
      end
   end
   // Undriven upper byte shows the port latch level
   assign addr = {pins.hi_oe_n ? HI_PORT : pins.hi_o,
      pins.lo_oe_n ? latch_q : pins.lo_o};
   // Store while write strobe low; idle lines toggle every cycle
   always @(posedge core_clk) begin
      junk_r <= ~junk_r;
      if (!pins.wr_n && !pins.ad_oe_n) begin
         mem[addr] <= pins.ad_o;
      end
   end
   assign data_i = !pins.rd_n ? mem[addr] : junk_r;
endmodule

//--- verif/external_data_memory_interface_tb_top.sv
// Self-checking testbench of the external data memory interface
`timescale 1ns/1ps
module external_data_memory_interface_tb_top;
   // ********************************
   // Stimulus, tasks and scenarios
   // ********************************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mv_rdata;
   logic [7:0] data_i;
   logic reg_wr = 1'b0, reg_rd = 1'b0, mv_req = 1'b0, mv_busy, mv_done;
   emi_pkg::emi_move_t mv = '0;
   emi_pkg::emi_pins_t pins;
   int error_cnt = 0, checks = 0;
   emi_top i_emi_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mv_req(mv_req), .mv(mv), .mv_busy(mv_busy),
      .mv_done(mv_done), .mv_rdata(mv_rdata), .data_i(data_i), .pins(pins));
   emi_sram_model #(.HI_PORT(8'h5a)) i_emi_sram_model (.core_clk(core_clk),
      .pins(pins), .data_i(data_i));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic move(input logic wr, wide, input logic [15:0] dp,
      input logic [7:0] ri, wd, output logic [7:0] n);
      @(posedge core_clk);
      mv <= '{wr, wide, dp, ri, wd};
      mv_req <= 1'b1;
      @(posedge core_clk);
      mv_req <= 1'b0;
      n = 8'd1;
      #1;
      while (mv_done !== 1'b1 && n < 8'd100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   task automatic t_regs();
      logic [7:0] ad [4] = '{8'h00, 8'h01, 8'h02, 8'h07};
      logic [7:0] ex [4] = '{8'h03, 8'h00, 8'hff, 8'h00};
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         rd_reg(ad[i], d);
         chk(d, ex[i]);
      end
      wr_reg(8'h00, 8'hff);
      rd_reg(8'h00, d);
      chk(d, 8'h1f);
   endtask
   task automatic t_timing();
      logic [7:0] cf [7] = '{8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h0c, 8'h0f};
      logic [7:0] tc [7] = '{8'hff, 8'h00, 8'h5a, 8'hc0, 8'h3c, 8'h00, 8'h03};
      logic [7:0] ln [7] = '{8'd27, 8'd6, 8'd15, 8'd9, 8'd21, 8'd8, 8'd17};
      logic [7:0] n;
      logic [15:0] a;
      for (int i = 0; i < 7; i++) begin
         a = 16'h4000 + 16'(i);
         wr_reg(8'h00, cf[i]);
         wr_reg(8'h02, tc[i]);
         move(1'b1, 1'b1, a, 8'h00, 8'h30 + 8'(i), n);
         chk(n, ln[i]);
         chk(i_emi_sram_model.mem[a], 8'h30 + 8'(i));
         move(1'b0, 1'b1, a, 8'h00, 8'h00, n);
         chk(n, ln[i]);
         chk(mv_rdata, 8'h30 + 8'(i));
      end
   endtask
   task automatic t_modes();
      logic [7:0] n;
      wr_reg(8'h00, 8'h10);
      wr_reg(8'h01, 8'h60);
      move(1'b1, 1'b1, 16'h2005, 8'h00, 8'ha5, n);
      chk(n, 8'd2);
      move(1'b0, 1'b0, 16'h0000, 8'h05, 8'h00, n);
      chk(mv_rdata, 8'ha5);
      rd_reg(8'h03, n);
      chk(n, 8'h00);
      wr_reg(8'h00, 8'h14);
      move(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00, n);
      chk(n, 8'd2);
      chk(mv_rdata, 8'ha5);
      move(1'b1, 1'b0, 16'h0000, 8'h33, 8'h3c, n);
      chk(i_emi_sram_model.mem[16'h5a33], 8'h3c);
      wr_reg(8'h00, 8'h18);
      wr_reg(8'h01, 8'h80);
      move(1'b1, 1'b0, 16'h0000, 8'h44, 8'h77, n);
      chk(i_emi_sram_model.mem[16'h8044], 8'h77);
      wr_reg(8'h00, 8'h1c);
      move(1'b1, 1'b0, 16'h0000, 8'h05, 8'h99, n);
      chk(i_emi_sram_model.mem[16'h5a05], 8'h99);
      i_emi_sram_model.mem[16'h0005] = 8'h66;
      move(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00, n);
      chk(mv_rdata, 8'h66);
      rd_reg(8'h03, n);
      chk(n, 8'h02);
   endtask
   task automatic end_sim();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Clock of 20 ns period
   always #10 core_clk = ~core_clk;
   // Reset, then the scenarios in order
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_timing();
      t_modes();
      end_sim();
   end
   // Watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      end_sim();
   end
endmodule
